// File: core/clsb_pkg.sv
// Package with opcodes, flag positions and cycle counts for the load/store/bit unit
package clsb_pkg;
    // Operation codes presented by the decoder
    localparam logic [4:0] OP_NOP = 5'h00;
    localparam logic [4:0] OP_LOAD = 5'h01;
    localparam logic [4:0] OP_LOAD_INC = 5'h02;
    localparam logic [4:0] OP_LOAD_DEC = 5'h03;
    localparam logic [4:0] OP_LOAD_DISP = 5'h04;
    localparam logic [4:0] OP_STORE = 5'h05;
    localparam logic [4:0] OP_STORE_INC = 5'h06;
    localparam logic [4:0] OP_STORE_DEC = 5'h07;
    localparam logic [4:0] OP_STORE_DISP = 5'h08;
    localparam logic [4:0] OP_STORE_DIRECT = 5'h09;
    localparam logic [4:0] OP_PMEM_READ = 5'h0a;
    localparam logic [4:0] OP_PMEM_READ_INC = 5'h0b;
    localparam logic [4:0] OP_PMEM_WRITE = 5'h0c;
    localparam logic [4:0] OP_PMEM_WRITE_INC = 5'h0d;
    localparam logic [4:0] OP_IO_READ = 5'h0e;
    localparam logic [4:0] OP_IO_WRITE = 5'h0f;
    localparam logic [4:0] OP_PUSH = 5'h10;
    localparam logic [4:0] OP_POP = 5'h11;
    localparam logic [4:0] OP_SHIFT_LEFT = 5'h12;
    localparam logic [4:0] OP_ROTATE_LEFT = 5'h13;
    localparam logic [4:0] OP_SHIFT_RIGHT = 5'h14;
    localparam logic [4:0] OP_ROTATE_RIGHT = 5'h15;
    localparam logic [4:0] OP_ARITH_RIGHT = 5'h16;
    localparam logic [4:0] OP_IO_BIT_SET = 5'h17;
    localparam logic [4:0] OP_IO_BIT_CLEAR = 5'h18;
    localparam logic [4:0] OP_COPY_TO_T = 5'h19;
    localparam logic [4:0] OP_COPY_FROM_T = 5'h1a;
    localparam logic [4:0] OP_FLAG_SET = 5'h1b;
    localparam logic [4:0] OP_FLAG_CLEAR = 5'h1c;
    // Flag register bit positions
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;
    localparam logic [7:0] FLAG_RESET = 8'h00;
    localparam logic [7:0] PAGE_EXT_RESET = 8'h00;
    localparam logic [15:0] STACK_RESET = 16'h3fff;
    // Base cycle counts
    localparam logic [2:0] CYC_ONE = 3'h1;
    localparam logic [2:0] CYC_TWO = 3'h2;
    localparam logic [2:0] CYC_PMEM = 3'h3;
    localparam logic [2:0] CYC_SRAM_EXTRA = 3'h1;
    // Internal SRAM window of data space
    localparam logic [15:0] SRAM_BASE = 16'h2000;
    localparam logic [15:0] SRAM_LAST = 16'h3fff;
endpackage : clsb_pkg

// File: core/clsb_mem_if.sv
// Interface carrying data-space accesses from the sequencer to the port stage
`timescale 1ns/1ps
`default_nettype none
interface clsb_mem_if;
    logic req;
    logic we;
    logic io;
    logic [15:0] addr;
    logic [7:0] wdata;
    modport src (output req, we, io, addr, wdata);
    modport dst (input req, we, io, addr, wdata);
endinterface : clsb_mem_if
`default_nettype wire

// File: core/clsb_shift_unit.sv
// Combinational shift, rotate and bit-copy unit with flag results
`timescale 1ns/1ps
`default_nettype none
module clsb_shift_unit (
    // Operation and operands
    input wire logic [4:0] op_i,
    input wire logic [7:0] val_i,
    input wire logic [2:0] bit_i,
    input wire logic [7:0] flags_i,
    // Results
    output logic [7:0] res_o,
    output logic [7:0] flags_o
);
    logic c_in;
    logic new_c;
    logic [7:0] r;
    logic [7:0] f;
    assign c_in = flags_i[clsb_pkg::FLAG_C];

    // Result byte and flags
    always_comb
    begin
        r = val_i;
        new_c = c_in;
        f = flags_i;
        case (op_i)
            clsb_pkg::OP_SHIFT_LEFT, clsb_pkg::OP_ROTATE_LEFT:
            begin
                r = {val_i[6:0], (op_i == clsb_pkg::OP_ROTATE_LEFT) ? c_in : 1'b0};
                new_c = val_i[7];
                f[clsb_pkg::FLAG_H] = val_i[3];
            end
            clsb_pkg::OP_SHIFT_RIGHT, clsb_pkg::OP_ROTATE_RIGHT:
            begin
                r = {(op_i == clsb_pkg::OP_ROTATE_RIGHT) ? c_in : 1'b0, val_i[7:1]};
                new_c = val_i[0];
            end
            clsb_pkg::OP_ARITH_RIGHT:
            begin
                r = {val_i[7], val_i[7:1]};
                new_c = val_i[0];
            end
            clsb_pkg::OP_COPY_TO_T: f[clsb_pkg::FLAG_T] = val_i[bit_i];
            clsb_pkg::OP_COPY_FROM_T: r[bit_i] = flags_i[clsb_pkg::FLAG_T];
            default: r = val_i;
        endcase
        if (op_i >= clsb_pkg::OP_SHIFT_LEFT && op_i <= clsb_pkg::OP_ARITH_RIGHT)
        begin
            f[clsb_pkg::FLAG_C] = new_c;
            f[clsb_pkg::FLAG_Z] = (r == 8'h00);
            f[clsb_pkg::FLAG_N] = r[7];
            f[clsb_pkg::FLAG_V] = r[7] ^ new_c;
            f[clsb_pkg::FLAG_S] = r[7] ^ r[7] ^ new_c;
        end
        res_o = r;
        flags_o = f;
    end
endmodule : clsb_shift_unit
`default_nettype wire

// File: core/clsb_mem_port.sv
// Registered data-space port stage driven through the memory interface
`timescale 1ns/1ps
`default_nettype none
module clsb_mem_port (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    // Request from sequencer
    clsb_mem_if.dst req_if,
    // Registered bus outputs
    output logic dmem_req_o,
    output logic dmem_we_o,
    output logic io_req_o,
    output logic io_we_o,
    output logic [15:0] addr_o,
    output logic [7:0] wdata_o
);
    // Registered copy of the request
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            dmem_req_o <= 1'b0;
            dmem_we_o <= 1'b0;
            io_req_o <= 1'b0;
            io_we_o <= 1'b0;
            addr_o <= 16'h0000;
            wdata_o <= 8'h00;
        end
        else
        begin
            dmem_req_o <= req_if.req & ~req_if.io;
            dmem_we_o <= req_if.req & ~req_if.io & req_if.we;
            io_req_o <= req_if.req & req_if.io;
            io_we_o <= req_if.req & req_if.io & req_if.we;
            addr_o <= req_if.addr;
            wdata_o <= req_if.wdata;
        end
    end
endmodule : clsb_mem_port
`default_nettype wire

// File: core/clsb_core.sv
// Sequencer for load, store, program memory, I/O, stack, bit and flag operations
`timescale 1ns/1ps
`default_nettype none
// Function
// - pre-decrement load lowers pointer, then reads decremented address; two cycles.
// - plain or post-increment load reads pointer address in one cycle; increment after.
// - displaced load reads pointer plus offset, pointer unchanged, two cycles.
// - direct store writes register to immediate address in two cycles.
// - plain or post-increment store writes at pointer in one cycle; increment after.
// - pre-decrement store lowers pointer then writes there; two cycles.
// - displaced store writes at pointer plus offset, pointer unchanged, two cycles.
// - program memory read takes three cycles; bare form targets low work register.
// - extended read prefixes page extension register to the pointer; also three cycles.
// - program memory write stores high:low work registers; increment form adds two.
// - I/O read and write move one byte in one cycle, flags untouched.
// - push takes one cycle, pop two; no flag changes.
// - left shifts move bit 7 into carry; fill zero or old carry; Z,C,N,V,H.
// - right shifts move bit 0 into carry; fill zero or carry; H untouched.
// - arithmetic right shift keeps sign bit, updates Z,C,N,V in one cycle.
// - I/O bit set or clear completes in one cycle, flags unchanged.
// - bit copy to transfer flag changes it; copy back leaves it.
// - flag set and clear force exactly one flag in one cycle.
// - global interrupt on and off set or clear the interrupt flag.
// - counts assume addresses outside internal SRAM; external accesses wait on ready.
// - loads or stores hitting internal SRAM take one extra cycle.
module clsb_core (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    // Decoded instruction
    input wire logic start_i,
    input wire logic [4:0] op_i,
    input wire logic [7:0] reg_val_i,
    input wire logic [15:0] ptr_i,
    input wire logic [15:0] imm_addr_i,
    input wire logic [5:0] disp_i,
    input wire logic [2:0] bit_i,
    input wire logic ext_pmem_i,
    input wire logic bare_pmem_i,
    // Work register values for program memory write
    input wire logic [7:0] low_work_register_i,
    input wire logic [7:0] high_work_register_i,
    input wire logic [7:0] page_ext_i,
    input wire logic page_ext_we_i,
    // Memory responses
    input wire logic [7:0] dmem_rdata_i,
    input wire logic dmem_ready_i,
    input wire logic [7:0] io_rdata_i,
    input wire logic [7:0] pmem_rdata_i,
    input wire logic pmem_write_ack_i,
    // Data and I/O port
    output logic dmem_req_o,
    output logic dmem_we_o,
    output logic io_req_o,
    output logic io_we_o,
    output logic [15:0] addr_o,
    output logic [7:0] wdata_o,
    // Program memory port
    output logic pmem_rd_o,
    output logic pmem_wr_o,
    output logic [23:0] pmem_addr_o,
    output logic [15:0] pmem_wdata_o,
    // Results
    output logic busy_o,
    output logic done_o,
    output logic rd_we_o,
    output logic low_work_we_o,
    output logic [7:0] rd_data_o,
    output logic ptr_we_o,
    output logic [15:0] ptr_o,
    output logic [7:0] flag_register_o,
    output logic [15:0] sp_o
);
    typedef enum logic [1:0] {
        CLSB_IDLE = 2'b00,
        CLSB_WAIT = 2'b01,
        CLSB_PWRITE = 2'b10
    } clsb_state_e;

    clsb_state_e state;
    clsb_state_e next_state;
    logic [2:0] count;
    logic [2:0] next_count;
    logic [4:0] cur_op;
    logic [15:0] cur_addr;
    logic [7:0] cur_val;
    logic [7:0] page_ext;
    logic [7:0] shift_res;
    logic [7:0] shift_flags;
    logic [7:0] io_bit_val;
    logic is_load;
    logic is_store;
    logic is_data;
    logic [15:0] eff_addr;
    logic [2:0] base_cyc;
    logic [2:0] total_cyc;
    logic pmem_wr_op;
    logic last;

    clsb_mem_if mem_if ();

    // Classify by operation
    function automatic logic [2:0] base_cycles(input logic [4:0] op);
        case (op)
            clsb_pkg::OP_LOAD_DEC, clsb_pkg::OP_LOAD_DISP, clsb_pkg::OP_STORE_DEC,
            clsb_pkg::OP_STORE_DISP, clsb_pkg::OP_STORE_DIRECT, clsb_pkg::OP_POP: base_cycles = clsb_pkg::CYC_TWO;
            clsb_pkg::OP_PMEM_READ, clsb_pkg::OP_PMEM_READ_INC: base_cycles = clsb_pkg::CYC_PMEM;
            default: base_cycles = clsb_pkg::CYC_ONE;
        endcase
    endfunction : base_cycles

    function automatic logic in_sram(input logic [15:0] a);
        in_sram = (a >= clsb_pkg::SRAM_BASE) && (a <= clsb_pkg::SRAM_LAST);
    endfunction : in_sram

    // Decoding of the incoming operation
    assign is_load = (op_i >= clsb_pkg::OP_LOAD) && (op_i <= clsb_pkg::OP_LOAD_DISP);
    assign is_store = (op_i >= clsb_pkg::OP_STORE) && (op_i <= clsb_pkg::OP_STORE_DIRECT);
    assign pmem_wr_op = (op_i == clsb_pkg::OP_PMEM_WRITE) || (op_i == clsb_pkg::OP_PMEM_WRITE_INC);
    assign eff_addr = (op_i == clsb_pkg::OP_LOAD_DEC || op_i == clsb_pkg::OP_STORE_DEC) ? ptr_i - 16'h0001 :
                      (op_i == clsb_pkg::OP_LOAD_DISP || op_i == clsb_pkg::OP_STORE_DISP) ? ptr_i + {10'h000, disp_i} :
                      (op_i == clsb_pkg::OP_STORE_DIRECT) ? imm_addr_i :
                      (op_i == clsb_pkg::OP_PUSH) ? sp_o :
                      (op_i == clsb_pkg::OP_POP) ? sp_o + 16'h0001 :
                      (op_i == clsb_pkg::OP_IO_READ || op_i == clsb_pkg::OP_IO_WRITE ||
                       op_i == clsb_pkg::OP_IO_BIT_SET || op_i == clsb_pkg::OP_IO_BIT_CLEAR) ? imm_addr_i :
                      ptr_i;
    assign is_data = is_load || is_store || op_i == clsb_pkg::OP_PUSH || op_i == clsb_pkg::OP_POP;
    assign base_cyc = base_cycles(op_i);
    assign total_cyc = base_cyc + ((is_load || is_store) && in_sram(eff_addr) ? clsb_pkg::CYC_SRAM_EXTRA : 3'h0);
    // Final cycle: count done and, for data-space operations, external ready seen
    // external wait
    assign last = (count == 3'h1) && (dmem_ready_i || !is_data_cur(cur_op));

    function automatic logic is_data_cur(input logic [4:0] op);
        is_data_cur = (op >= clsb_pkg::OP_LOAD && op <= clsb_pkg::OP_STORE_DIRECT) ||
                      op == clsb_pkg::OP_PUSH || op == clsb_pkg::OP_POP;
    endfunction : is_data_cur

    // Shift and bit-copy datapath
    clsb_shift_unit u_shift (
        .op_i(op_i),
        .val_i(reg_val_i),
        .bit_i(bit_i),
        .flags_i(flag_register_o),
        .res_o(shift_res),
        .flags_o(shift_flags)
    );

    assign io_bit_val = (op_i == clsb_pkg::OP_IO_BIT_SET) ? (io_rdata_i | (8'h01 << bit_i)) :
                        (io_rdata_i & ~(8'h01 << bit_i));

    // Request to the port stage
    // I/O read and write
    assign mem_if.req = start_i && !busy_o && (is_data || op_i == clsb_pkg::OP_IO_READ ||
                        op_i == clsb_pkg::OP_IO_WRITE || op_i == clsb_pkg::OP_IO_BIT_SET ||
                        op_i == clsb_pkg::OP_IO_BIT_CLEAR);
    assign mem_if.we = is_store || op_i == clsb_pkg::OP_PUSH || op_i == clsb_pkg::OP_IO_WRITE ||
                       op_i == clsb_pkg::OP_IO_BIT_SET || op_i == clsb_pkg::OP_IO_BIT_CLEAR;
    assign mem_if.io = op_i == clsb_pkg::OP_IO_READ || op_i == clsb_pkg::OP_IO_WRITE ||
                       op_i == clsb_pkg::OP_IO_BIT_SET || op_i == clsb_pkg::OP_IO_BIT_CLEAR;
    assign mem_if.addr = (state == CLSB_IDLE) ? eff_addr : cur_addr;
    assign mem_if.wdata = (op_i == clsb_pkg::OP_IO_BIT_SET || op_i == clsb_pkg::OP_IO_BIT_CLEAR) ?
                          io_bit_val : reg_val_i;

    clsb_mem_port u_port (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .req_if(mem_if),
        .dmem_req_o(dmem_req_o),
        .dmem_we_o(dmem_we_o),
        .io_req_o(io_req_o),
        .io_we_o(io_we_o),
        .addr_o(addr_o),
        .wdata_o(wdata_o)
    );

    // Next state selection
    always_comb
    begin
        next_state = state;
        next_count = count;
        case (state)
            CLSB_IDLE:
            begin
                if (start_i && pmem_wr_op)
                    next_state = CLSB_PWRITE;
                else if (start_i && (total_cyc > 3'h1 || is_data))
                begin
                    next_state = CLSB_WAIT;
                    next_count = total_cyc;
                end
            end
            CLSB_WAIT:
            begin
                if (last)
                    next_state = CLSB_IDLE;
                else if (count != 3'h1)
                    next_count = count - 3'h1;
            end
            CLSB_PWRITE:
                if (pmem_write_ack_i)
                    next_state = CLSB_IDLE;
            default: next_state = CLSB_IDLE;
        endcase
    end

    // State and captured operation
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            state <= CLSB_IDLE;
            count <= 3'h0;
            cur_op <= clsb_pkg::OP_NOP;
            cur_addr <= 16'h0000;
            cur_val <= 8'h00;
        end
        else
        begin
            state <= next_state;
            count <= next_count;
            if (state == CLSB_IDLE && start_i)
            begin
                cur_op <= op_i;
                cur_addr <= eff_addr;
                cur_val <= reg_val_i;
            end
        end
    end

    // Page extension register, loaded by software writes
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            page_ext <= clsb_pkg::PAGE_EXT_RESET;
        else if (page_ext_we_i)
            page_ext <= page_ext_i;
    end

    // Program memory port
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            pmem_rd_o <= 1'b0;
            pmem_wr_o <= 1'b0;
            pmem_addr_o <= 24'h000000;
            pmem_wdata_o <= 16'h0000;
        end
        else
        begin
            pmem_rd_o <= state == CLSB_IDLE && start_i &&
                         (op_i == clsb_pkg::OP_PMEM_READ || op_i == clsb_pkg::OP_PMEM_READ_INC);
            if (state == CLSB_IDLE && start_i)
                pmem_addr_o <= {(ext_pmem_i || pmem_wr_op) ? page_ext : 8'h00, ptr_i};
            if (state == CLSB_IDLE && start_i && pmem_wr_op)
                pmem_wdata_o <= {high_work_register_i, low_work_register_i};
            pmem_wr_o <= next_state == CLSB_PWRITE;
        end
    end

    // Stack pointer
    // push and pop
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            sp_o <= clsb_pkg::STACK_RESET;
        else if (state == CLSB_IDLE && start_i && op_i == clsb_pkg::OP_PUSH)
            sp_o <= sp_o - 16'h0001;
        else if (state == CLSB_IDLE && start_i && op_i == clsb_pkg::OP_POP)
            sp_o <= sp_o + 16'h0001;
    end

    // Results, pointer update and flag register
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            busy_o <= 1'b0;
            done_o <= 1'b0;
            rd_we_o <= 1'b0;
            low_work_we_o <= 1'b0;
            rd_data_o <= 8'h00;
            ptr_we_o <= 1'b0;
            ptr_o <= 16'h0000;
            flag_register_o <= clsb_pkg::FLAG_RESET;
        end
        else
        begin
            busy_o <= next_state != CLSB_IDLE;
            done_o <= 1'b0;
            rd_we_o <= 1'b0;
            low_work_we_o <= 1'b0;
            ptr_we_o <= 1'b0;
            if (state == CLSB_IDLE && start_i && next_state == CLSB_IDLE)
            begin
                // Single-cycle operations without a data-space access finish here
                done_o <= 1'b1;
                rd_we_o <= op_i == clsb_pkg::OP_IO_READ || (op_i >= clsb_pkg::OP_SHIFT_LEFT &&
                           op_i <= clsb_pkg::OP_ARITH_RIGHT) || op_i == clsb_pkg::OP_COPY_FROM_T;
                rd_data_o <= (op_i == clsb_pkg::OP_IO_READ) ? io_rdata_i : shift_res;
                flag_register_o <= shift_flags;
                if (op_i == clsb_pkg::OP_FLAG_SET)
                    flag_register_o[bit_i] <= 1'b1;
                else if (op_i == clsb_pkg::OP_FLAG_CLEAR)
                    flag_register_o[bit_i] <= 1'b0;
            end
            else if (state == CLSB_WAIT && last)
            begin
                done_o <= 1'b1;
                rd_we_o <= (cur_op >= clsb_pkg::OP_LOAD && cur_op <= clsb_pkg::OP_LOAD_DISP) ||
                           cur_op == clsb_pkg::OP_POP ||
                           ((cur_op == clsb_pkg::OP_PMEM_READ || cur_op == clsb_pkg::OP_PMEM_READ_INC) && !bare_pmem_i);
                low_work_we_o <= (cur_op == clsb_pkg::OP_PMEM_READ) && bare_pmem_i;
                rd_data_o <= (cur_op == clsb_pkg::OP_PMEM_READ || cur_op == clsb_pkg::OP_PMEM_READ_INC) ?
                             pmem_rdata_i : dmem_rdata_i;
                ptr_we_o <= cur_op == clsb_pkg::OP_LOAD_DEC || cur_op == clsb_pkg::OP_STORE_DEC ||
                            cur_op == clsb_pkg::OP_LOAD_INC || cur_op == clsb_pkg::OP_PMEM_READ_INC ||
                            cur_op == clsb_pkg::OP_STORE_INC;
                ptr_o <= (cur_op == clsb_pkg::OP_LOAD_DEC || cur_op == clsb_pkg::OP_STORE_DEC) ?
                         cur_addr : cur_addr + 16'h0001;
            end
            else if (state == CLSB_PWRITE && pmem_write_ack_i)
            begin
                done_o <= 1'b1;
                ptr_we_o <= cur_op == clsb_pkg::OP_PMEM_WRITE_INC;
                ptr_o <= cur_addr + 16'h0002;
            end
        end
    end
endmodule : clsb_core
`default_nettype wire

// File: sim/clsb_partner.sv
// Data, I/O and program memory model beside the sequencer
`timescale 1ns/1ps
`default_nettype none
module clsb_partner #(parameter int ACK_WAIT = 3) (
    // Requests
    input wire logic clk_sys_i, slow_i, dmem_req_o, dmem_we_o, io_req_o, io_we_o, pmem_wr_o,
    input wire logic [15:0] addr_o, imm_addr_i,
    input wire logic [7:0] wdata_o,
    input wire logic [23:0] pmem_addr_o,
    // Answers
    output logic [7:0] dmem_rdata_i, io_rdata_i, pmem_rdata_i,
    output logic dmem_ready_i, pmem_write_ack_i
);
    logic [7:0] mem [0:65535];
    logic [7:0] io [0:255];
    int hold = 0, wt = 0;
    // Data reads follow the held address
    assign dmem_rdata_i = mem[addr_o];
    assign io_rdata_i = io[imm_addr_i[7:0]];
    assign pmem_rdata_i = pmem_addr_o[7:0] ^ pmem_addr_o[15:8] ^ pmem_addr_o[23:16];
    assign dmem_ready_i = !(slow_i && (dmem_req_o || hold != 0));
    initial pmem_write_ack_i = 1'b0;
    // Writes and late write acceptance
    always @(posedge clk_sys_i)
    begin
        if (dmem_req_o && dmem_we_o) mem[addr_o] <= wdata_o;
        if (io_req_o && io_we_o) io[addr_o[7:0]] <= wdata_o;
        hold <= dmem_req_o && slow_i ? 2 : hold > 0 ? hold - 1 : 0;
        wt <= pmem_wr_o && !pmem_write_ack_i ? wt + 1 : 0;
        pmem_write_ack_i <= pmem_wr_o && wt == ACK_WAIT;
    end
endmodule : clsb_partner
`default_nettype wire

// File: sim/clsb_core_assertions.sv
// Port-level timing checks for the sequencer
`timescale 1ns/1ps
`default_nettype none
module clsb_core_assertions (
    input wire logic clk_sys_i, rst_b_i, start_i, busy_o, done_o, io_req_o, io_we_o,
    input wire logic dmem_ready_i, pmem_wr_o, pmem_write_ack_i,
    input wire logic [4:0] op_i,
    input wire logic [15:0] ptr_i, addr_o,
    input wire logic [5:0] disp_i,
    input wire logic [2:0] bit_i,
    input wire logic [7:0] flag_register_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);
    // Accepted request of one kind
    sequence s_go(logic [4:0] o);
        start_i && !busy_o && op_i == o;
    endsequence
    a_io_read_flags: assert property (s_go(clsb_pkg::OP_IO_READ) |=> done_o && $stable(flag_register_o))
        else $error("io read slow or flags moved");
    a_io_write_pulse: assert property (s_go(clsb_pkg::OP_IO_WRITE) |=> io_req_o && io_we_o)
        else $error("io write missing");
    a_predec_addr: assert property (s_go(clsb_pkg::OP_LOAD_DEC) |=> addr_o == $past(ptr_i) - 16'h0001)
        else $error("pre-decrement address wrong");
    a_disp_addr: assert property (s_go(clsb_pkg::OP_LOAD_DISP) |=>
        addr_o == $past(ptr_i) + {10'h000, $past(disp_i)})
        else $error("displaced address wrong");
    a_predec_two: assert property ((s_go(clsb_pkg::OP_LOAD_DEC) ##0 ptr_i <= 16'h2000 && ptr_i != 16'h0000
        && dmem_ready_i) |=> !done_o [*2] ##1 done_o)
        else $error("pre-decrement count wrong");
    a_pmem_three: assert property (s_go(clsb_pkg::OP_PMEM_READ) |=> !done_o [*3] ##1 done_o)
        else $error("program read count wrong");
    a_pmem_ack_done: assert property (pmem_wr_o && pmem_write_ack_i |=> done_o)
        else $error("no completion after acceptance");
    a_flag_set_one: assert property (s_go(clsb_pkg::OP_FLAG_SET) |=>
        flag_register_o == ($past(flag_register_o) | (8'h01 << $past(bit_i))))
        else $error("flag set wrong");
endmodule : clsb_core_assertions
`default_nettype wire

// File: sim/tb.sv
// Random and corner stimulus for the sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk_sys_i = 1'b0, rst_b_i, start_i, ext_pmem_i, bare_pmem_i, page_ext_we_i, slow_i, dmem_ready_i;
    logic pmem_write_ack_i, dmem_req_o, dmem_we_o, io_req_o, io_we_o, pmem_rd_o, pmem_wr_o, busy_o, done_o;
    logic rd_we_o, low_work_we_o, ptr_we_o;
    logic [2:0] bit_i;
    logic [4:0] op_i;
    logic [5:0] disp_i;
    logic [7:0] reg_val_i, low_work_register_i, high_work_register_i, page_ext_i, dmem_rdata_i, io_rdata_i;
    logic [7:0] pmem_rdata_i, wdata_o, rd_data_o, flag_register_o, v, f;
    logic [15:0] ptr_i, imm_addr_i, addr_o, ptr_o, sp_o, pmem_wdata_o, p;
    logic [23:0] pmem_addr_o;
    int n_errors = 0, checked = 0, ncyc;
    // Clock and parties
    always #50 clk_sys_i = ~clk_sys_i;
    clsb_core uut (.*);
    clsb_partner ram (.*);
    task automatic print_verdict;
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e)
        begin
            n_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    // Issue one operation and count cycles to completion
    task automatic go(input logic [4:0] o);
        @(negedge clk_sys_i); // Idle cycle after done
        op_i = o;
        start_i = 1'b1;
        @(negedge clk_sys_i);
        start_i = 1'b0;
        for (ncyc = 0; done_o !== 1'b1 && ncyc < 40; ncyc++) @(negedge clk_sys_i);
        if (ncyc == 40)
        begin
            n_errors++;
            print_verdict();
        end
    endtask : go
    // Expected shift result as {V,N,Z,C,result}
    function automatic logic [11:0] shx(input int j, input logic [7:0] d, input logic c);
        logic [8:0] r;
        r = j == 0 ? {d, 1'b0} : j == 1 ? {d, c} : j == 2 ? {1'b0, d} : j == 3 ? {c, d} : {d[7], d};
        if (j > 1) r = {r[0], r[8:1]};
        return {r[8] ^ r[7], r[7], r[7:0] == 8'h00, r[8], r[7:0]};
    endfunction : shx
    initial
    begin
        {rst_b_i, start_i, ext_pmem_i, bare_pmem_i, page_ext_we_i, slow_i, bit_i, op_i, disp_i} = '0;
        {reg_val_i, low_work_register_i, high_work_register_i, page_ext_i, ptr_i, imm_addr_i} = '0;
        void'($urandom(32'hbe35));
        repeat (3) @(negedge clk_sys_i);
        rst_b_i = 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            // Pointer modes, direct and displaced transfers
            p = 16'h0100 + 16'($urandom_range(16'h1e00));
            v = 8'($urandom);
            {ptr_i, reg_val_i, disp_i} = {p, v, 6'($urandom)};
            go(clsb_pkg::OP_STORE_INC);
            chk({ncyc[3:0], ptr_we_o, ptr_o}, {4'h1, 1'b1, p + 16'h0001});
            ptr_i = p + 16'h0001;
            go(clsb_pkg::OP_LOAD_DEC);
            chk({ncyc[3:0], ptr_o, rd_data_o}, {4'h2, p, v});
            reg_val_i = ~v;
            go(clsb_pkg::OP_STORE_DISP);
            chk({ncyc[3:0], ptr_we_o}, {4'h2, 1'b0});
            slow_i = i[0];
            go(clsb_pkg::OP_LOAD_DISP);
            chk({ncyc > 2, ptr_we_o, rd_data_o}, {slow_i, 1'b0, ~v});
            {slow_i, imm_addr_i} = {1'b0, clsb_pkg::SRAM_BASE + {8'h00, v}};
            go(clsb_pkg::OP_STORE_DIRECT);
            chk(ncyc, 3);
            ptr_i = imm_addr_i;
            go(clsb_pkg::OP_LOAD);
            chk({ncyc[3:0], rd_data_o}, {4'h2, ~v});
            // I/O byte and bit access
            {imm_addr_i, bit_i, f} = {8'h00, v, 3'($urandom), flag_register_o};
            go(clsb_pkg::OP_IO_WRITE);
            go(clsb_pkg::OP_IO_BIT_SET);
            go(clsb_pkg::OP_IO_READ);
            chk({ncyc[3:0], rd_data_o, flag_register_o}, {4'h0, ~v | (8'h01 << bit_i), f});
            go(clsb_pkg::OP_COPY_TO_T);
            chk(flag_register_o[6], reg_val_i[bit_i]);
            // Shift and rotate family
            for (int j = 0; j < 5; j++)
            begin
                f = flag_register_o;
                reg_val_i = i == 0 ? 8'h80 : 8'($urandom);
                go(clsb_pkg::OP_SHIFT_LEFT + 5'(j));
                chk({flag_register_o[3:0], rd_data_o}, shx(j, reg_val_i, f[0]));
            end
            // Stack round trip
            go(clsb_pkg::OP_PUSH);
            go(clsb_pkg::OP_POP);
            chk({ncyc[3:0], rd_we_o, rd_data_o, sp_o}, {4'h2, 1'b1, reg_val_i, clsb_pkg::STACK_RESET});
            // Program memory read and write
            {page_ext_i, page_ext_we_i, ext_pmem_i, bare_pmem_i, ptr_i} = {8'($urandom), 1'b1, i[1], i[0], p};
            @(negedge clk_sys_i);
            page_ext_we_i = 1'b0;
            go(i[0] ? clsb_pkg::OP_PMEM_READ : clsb_pkg::OP_PMEM_READ_INC);
            f = (ext_pmem_i ? page_ext_i : 8'h00) ^ p[15:8] ^ p[7:0];
            chk({ncyc[3:0], low_work_we_o, rd_data_o, ptr_o}, {4'h3, i[0], f, i[0] ? ptr_o : p + 16'h0001});
            {low_work_register_i, high_work_register_i} = {v, ~v};
            go(clsb_pkg::OP_PMEM_WRITE_INC);
            chk({pmem_wdata_o, ptr_o}, {~v, v, p + 16'h0002});
            chk(pmem_addr_o, {page_ext_i, p});
        end
        // Every flag forced on and off
        for (int i = 0; i < 8; i++)
        begin
            {bit_i, f} = {3'(i), flag_register_o | (8'h01 << i)};
            go(clsb_pkg::OP_FLAG_SET);
            chk(flag_register_o, f);
            go(clsb_pkg::OP_FLAG_CLEAR);
            chk(flag_register_o, {f & ~(8'h01 << i)});
        end
        print_verdict();
    end
endmodule : tb
bind clsb_core clsb_core_assertions chk_i (.*);
`default_nettype wire
